// *** test_ual_link_top.sv ***
`timescale 1ns/100ps
module test_ual_link_top;
  localparam int OFF = 20;
  localparam int BON = 4;
  localparam int BPER = 16;
  logic sys_clk, reset_n, connect_cmd, disconnect_cmd, addr_set, suspended, ack_done;
  logic bus_pwr, resume_k, start, vbus_sense, rx_dp, rx_dm, ref_osc_in, chk_rx;
  logic ref_osc_out, ref_clk_ok, dp_pullup_en, rx_enabled, rx_bit, rx_bit_valid, line_se0, wake_req, link_led_n;
  logic [15:0] word;
  logic [31:0] lfsr_q = 32'hb9d435d2;
  logic [7:0] hist;
  int n_mismatch, n_tests, n_valid, cyc, n;

  ual_link_top #(.LED_OFF_CYC(OFF), .BLINK_ON_CYC(BON), .BLINK_PERIOD_CYC(BPER)) u_ual_link_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .connect_cmd(connect_cmd), .disconnect_cmd(disconnect_cmd),
    .vbus_sense(vbus_sense), .addr_set(addr_set), .suspended(suspended), .ack_done(ack_done),
    .rx_dp(rx_dp), .rx_dm(rx_dm), .ref_osc_in(ref_osc_in), .ref_osc_out(ref_osc_out),
    .ref_clk_ok(ref_clk_ok), .dp_pullup_en(dp_pullup_en), .rx_enabled(rx_enabled), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .line_se0(line_se0), .wake_req(wake_req), .link_led_n(link_led_n));
  ual_host_model u_ual_host_model (.sys_clk(sys_clk), .bus_pwr(bus_pwr), .resume_k(resume_k),
    .start(start), .word(word), .vbus_sense(vbus_sense), .rx_dp(rx_dp), .rx_dm(rx_dm));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic in_win(input int v, input int exp);
    return v >= exp - 1 && v <= exp + 2;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc_n(1);
    s = 1'b0;
  endtask
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // second ack lands gap cycles after the first; gap 0 means a single ack
  task automatic ack_off(input int gap);
    n = 0;
    for (int i = 0; i < gap + OFF + 10; i++) begin
      ack_done = (i == 0 || i == gap);
      cyc_n(1);
      n += int'(link_led_n === 1'b1);
    end
    ack_done = 1'b0;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial forever begin
    cyc_n(2);
    ref_osc_in = ~ref_osc_in;
  end
  // the centre sample of a bit is five to seven edges old when its valid pulse is seen
  always @(posedge sys_clk) begin
    hist <= {hist[6:0], rx_dp};
    cyc++;
    if (chk_rx && rx_bit_valid === 1'b1) begin
      n_valid++;
      check("rx bit", rx_bit, hist[5]);
    end
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {reset_n, connect_cmd, disconnect_cmd, addr_set, ack_done, bus_pwr, resume_k, start, chk_rx} = '0;
    {suspended, ref_osc_in} = 2'b10;
    word = 16'h0000;
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    check("pullup after reset", dp_pullup_en, 0);
    check("led after reset", link_led_n, 1);
    chk_rx = 1'b1;
    pulse(connect_cmd);
    cyc_n(40);
    chk_rx = 1'b0;
    check("pullup no vbus", dp_pullup_en, 0);
    check("rx coupled", rx_enabled, 0);
    check("valid count", n_valid, 0);
    check("wake on noise", wake_req, 0);
    bus_pwr = 1'b1;
    cyc_n(8);
    check("pullup with vbus", dp_pullup_en, 1);
    suspended = 1'b0;
    cyc_n(20);
    n = 0;
    for (int i = 0; i < 2 * BPER; i++) begin
      cyc_n(1);
      n += int'(link_led_n === 1'b0);
    end
    check("blink lit cycles", n, 2 * BON);
    addr_set = 1'b1;
    cyc_n(3);
    check("led addressed", link_led_n, 0);
    for (int g = 0; g < 3; g++) begin
      ack_off(g * g * g + g);
      check("ack off length", in_win(n, OFF + g * g * g + g), 1);
    end
    $display("done: attach and led");
    for (int k = 0; k < 3; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      word = lfsr_q[15:0];
      n_valid = 0;
      chk_rx = 1'b1;
      pulse(start);
      cyc_n(72);
      chk_rx = 1'b0;
      check("valid count", in_win(n_valid, 18), 1);
    end
    $display("done: receive");
    suspended = 1'b1;
    cyc_n(3);
    check("led suspended", link_led_n, 1);
    pulse(ack_done);
    cyc_n(3);
    check("led suspended ack", link_led_n, 1);
    resume_k = 1'b1;
    cyc_n(10);
    check("wake on k", wake_req, 1);
    {resume_k, suspended} = 2'b00;
    for (int k = 0; k < 12; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (lfsr_q[0])
        pulse(disconnect_cmd);
      else
        pulse(connect_cmd);
      cyc_n(3);
      check("pullup reattach", dp_pullup_en, !lfsr_q[0]);
    end
    // detach and reattach on consecutive edges: one cycle without pull-up
    disconnect_cmd = 1'b1;
    cyc_n(1);
    {disconnect_cmd, connect_cmd} = 2'b01;
    cyc_n(1);
    connect_cmd = 1'b0;
    check("pullup gap", dp_pullup_en, 0);
    cyc_n(1);
    check("pullup back", dp_pullup_en, 1);
    // step off the reference toggle instant before comparing the inverter
    #5;
    check("ref seen", ref_clk_ok, 1);
    check("ref out", ref_osc_out, !ref_osc_in);
    $display("done: suspend and reattach");
    close_out();
  end
endmodule

// *** ual_host_model.sv ***
`timescale 1ns/100ps
module ual_host_model (
  input wire logic sys_clk,
  input wire logic bus_pwr,
  input wire logic resume_k,
  input wire logic start,
  input wire logic [15:0] word,
  output logic vbus_sense,
  output logic rx_dp,
  output logic rx_dm
);
  logic [15:0] sh_q = 16'h0000;
  logic [4:0] left_q = 5'h00;
  logic [1:0] div_q = 2'h0;
  logic noise_q = 1'b0;

  // four clock cycles per bit, msb first
  always_ff @(posedge sys_clk) begin
    noise_q <= ~noise_q;
    div_q <= div_q + 2'h1;
    if (start) begin
      sh_q <= word;
      left_q <= 5'h10;
      div_q <= 2'h0;
    end else if (left_q != 5'h00 && div_q == 2'h3) begin
      sh_q <= {sh_q[14:0], 1'b0};
      left_q <= left_q - 5'h01;
    end
  end

  // unpowered cable: lines flip between j and k each cycle, the worst case for a false wake
  always_comb begin
    vbus_sense = bus_pwr;
    rx_dp = 1'b1;
    rx_dm = 1'b0;
    if (!bus_pwr) begin
      rx_dp = noise_q;
      rx_dm = ~noise_q;
    end else if (resume_k) begin
      rx_dp = 1'b0;
      rx_dm = 1'b1;
    end else if (left_q != 5'h00) begin
      rx_dp = sh_q[15];
      rx_dm = ~sh_q[15];
    end
  end
endmodule

// *** ual_link_top.sv ***
`timescale 1ns/100ps
module ual_link_top #(
  parameter int unsigned LED_OFF_CYC = ual_pkg::LED_OFF_CYC,
  parameter int unsigned BLINK_ON_CYC = ual_pkg::BLINK_ON_CYC,
  parameter int unsigned BLINK_PERIOD_CYC = ual_pkg::BLINK_PERIOD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic connect_cmd,
  input wire logic disconnect_cmd,
  input wire logic vbus_sense,
  input wire logic addr_set,
  input wire logic suspended,
  input wire logic ack_done,
  input wire logic rx_dp,
  input wire logic rx_dm,
  input wire logic ref_osc_in,
  output logic ref_osc_out,
  output logic ref_clk_ok,
  output logic dp_pullup_en,
  output logic rx_enabled,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic line_se0,
  output logic wake_req,
  output logic link_led_n
);

  localparam logic [22:0] OFF_LOAD = 23'(LED_OFF_CYC);
  localparam logic [22:0] BLINK_ON = 23'(BLINK_ON_CYC);
  localparam logic [22:0] BLINK_LAST = 23'(BLINK_PERIOD_CYC - 1);

  logic [3:0] pins_s;
  logic vbus_ok;
  logic dp_s;
  logic dm_s;
  logic ref_s;

  ual_pin_sync #(
    .W(ual_pkg::PIN_W),
    .RST_VAL(ual_pkg::PIN_RST)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .d({ref_osc_in, rx_dm, rx_dp, vbus_sense}),
    .q(pins_s)
  );

  assign vbus_ok = pins_s[ual_pkg::PIN_VBUS];
  assign dp_s = pins_s[ual_pkg::PIN_DP];
  assign dm_s = pins_s[ual_pkg::PIN_DM];
  assign ref_s = pins_s[ual_pkg::PIN_REF];

  // inverting oscillator stage towards the crystal
  assign ref_osc_out = ~ref_osc_in;

  // reference presence: count rising edges per window; the multiplied core clock is only
  // trusted once a window holds at least half the nominal number of reference edges
  logic ref_prev_q;
  logic [7:0] ref_win_q;
  logic [7:0] ref_edges_q;
  logic ref_ok_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_prev_q <= 1'b0;
      ref_win_q <= 8'h00;
      ref_edges_q <= 8'h00;
      ref_ok_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_s;
      ref_win_q <= ref_win_q + 8'h01;
      if (ref_win_q == 8'hff) begin
        ref_ok_q <= (ref_edges_q >= ual_pkg::REF_EDGES_MIN);
        ref_edges_q <= 8'h00;
      end else if (ref_s && !ref_prev_q && ref_edges_q != 8'hff) begin
        ref_edges_q <= ref_edges_q + 8'h01;
      end
    end
  end

  assign ref_clk_ok = ref_ok_q;

  // attach control: the request survives a loss of bus power, the pull-up does not
  ual_pkg::ual_attach_e attach_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      attach_q <= ual_pkg::UAL_DETACHED;
    end else begin
      case (attach_q)
        ual_pkg::UAL_DETACHED: begin
          if (connect_cmd && !disconnect_cmd) begin
            attach_q <= ual_pkg::UAL_ATTACHED;
          end
        end
        ual_pkg::UAL_ATTACHED: begin
          if (disconnect_cmd) begin
            attach_q <= ual_pkg::UAL_DETACHED;
          end
        end
        default: begin
          attach_q <= ual_pkg::UAL_DETACHED;
        end
      endcase
    end
  end

  logic pullup_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pullup_q <= 1'b0;
    end else begin
      pullup_q <= (attach_q == ual_pkg::UAL_ATTACHED) && vbus_ok;
    end
  end

  assign dp_pullup_en = pullup_q;

  // receiver gating: without bus power the lines read as idle J
  logic line_dp;
  logic line_dm;

  assign rx_enabled = vbus_ok;
  assign line_dp = vbus_ok ? dp_s : 1'b1;
  assign line_dm = vbus_ok ? dm_s : 1'b0;

  // bit recovery: every D+ transition re-centres the phase, so drift and jitter are
  // tracked one bit at a time; sys_clk acts as the oversampling clock
  logic [1:0] phase_q;
  logic dp_prev_q;
  logic bit_q;
  logic bit_valid_q;
  logic se0_q;
  logic wake_q;
  logic line_edge;

  assign line_edge = line_dp != dp_prev_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 2'h0;
      dp_prev_q <= 1'b1;
    end else begin
      dp_prev_q <= line_dp;
      if (line_edge) begin
        phase_q <= 2'h0;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_q <= 1'b1;
      bit_valid_q <= 1'b0;
      se0_q <= 1'b0;
    end else begin
      bit_valid_q <= vbus_ok && (phase_q == ual_pkg::SAMPLE_PHASE);
      if (phase_q == ual_pkg::SAMPLE_PHASE) begin
        bit_q <= line_dp;
      end
      se0_q <= !line_dp && !line_dm;
    end
  end

  // resume signalling (K) while suspended raises a wake request, only with bus power
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= suspended && vbus_ok && !line_dp && line_dm;
    end
  end

  assign rx_bit = bit_q;
  assign rx_bit_valid = bit_valid_q;
  assign line_se0 = se0_q;
  assign wake_req = wake_q;

  // link indicator
  logic [22:0] off_cnt_q;
  logic [22:0] blink_cnt_q;
  logic led_n_q;
  ual_pkg::ual_led_e led_st;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      off_cnt_q <= 23'h000000;
    end else if (!pullup_q || suspended) begin
      off_cnt_q <= 23'h000000;
    end else if (ack_done) begin
      off_cnt_q <= OFF_LOAD;
    end else if (off_cnt_q != 23'h000000) begin
      off_cnt_q <= off_cnt_q - 23'h000001;
    end
  end

  // blink phase runs only while enumerating, so every enumeration starts with a flash
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt_q <= 23'h000000;
    end else if (led_st != ual_pkg::UAL_LED_BLINK || blink_cnt_q >= BLINK_LAST) begin
      blink_cnt_q <= 23'h000000;
    end else begin
      blink_cnt_q <= blink_cnt_q + 23'h000001;
    end
  end

  always_comb begin
    if (!pullup_q || suspended) begin
      led_st = ual_pkg::UAL_LED_DARK;
    end else if (off_cnt_q != 23'h000000) begin
      led_st = ual_pkg::UAL_LED_ACKOFF;
    end else if (addr_set) begin
      led_st = ual_pkg::UAL_LED_ON;
    end else begin
      led_st = ual_pkg::UAL_LED_BLINK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      led_n_q <= 1'b1;
    end else begin
      case (led_st)
        ual_pkg::UAL_LED_ON: led_n_q <= 1'b0;
        ual_pkg::UAL_LED_BLINK: led_n_q <= !(blink_cnt_q < BLINK_ON);
        default: led_n_q <= 1'b1;
      endcase
    end
  end

  assign link_led_n = led_n_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_pullup_detached: assert property (attach_q == ual_pkg::UAL_DETACHED |=> !dp_pullup_en)
    else $error("pull-up on while detached");
  a_pullup_needs_vbus: assert property (!vbus_ok |=> !dp_pullup_en)
    else $error("pull-up on without bus power");
  a_rx_isolated: assert property (!vbus_ok |=> !rx_bit_valid && !wake_req && !line_se0)
    else $error("receiver active without bus power");
  a_reattach_cycle: assert property (disconnect_cmd ##1 (connect_cmd && !disconnect_cmd && vbus_ok)
    |=> !dp_pullup_en ##1 dp_pullup_en)
    else $error("detach then reattach did not follow the commands");
  a_blink_short: assert property (led_st == ual_pkg::UAL_LED_BLINK && blink_cnt_q >= BLINK_ON
    |=> link_led_n)
    else $error("link led lit past its blink pulse");
  a_addr_steady: assert property (led_st == ual_pkg::UAL_LED_ON |=> !link_led_n)
    else $error("link led not steady after address set");
  a_ack_dark: assert property (ack_done && pullup_q && !suspended
    |=> off_cnt_q == OFF_LOAD ##1 link_led_n)
    else $error("ack did not start the led off interval");
  a_suspend_dark: assert property (suspended |=> link_led_n)
    else $error("link led lit during suspend");
  a_sample_phase: assert property (rx_bit_valid |-> $past(phase_q) == ual_pkg::SAMPLE_PHASE
    && $past(vbus_ok))
    else $error("bit taken off the centre sample");
  a_ref_window: assert property ($changed(ref_clk_ok) |-> $past(ref_win_q) == 8'hff)
    else $error("reference status changed mid window");

  c_attach_on: cover property (connect_cmd ##1 !dp_pullup_en ##1 dp_pullup_en);
  c_ack_restart: cover property (ack_done ##[1:20] (ack_done && off_cnt_q != 23'h000000));
  c_suspend_addr: cover property (suspended && addr_set && pullup_q);
  c_wake: cover property ($rose(wake_req));

endmodule

// *** ual_pin_sync.sv ***
`timescale 1ns/100ps
module ual_pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // s1 feeds only s2; a bit changes once stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end

  // checked bit by bit: a noisy neighbour bit must not mask or fake a legal change
  a_sync_agree: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ((q ^ $past(q)) & (($past(s2_q) ^ $past(s3_q)) | (q ^ $past(s3_q)))) == '0)
    else $error("synchronised output changed without stage agreement");

endmodule

// *** ual_pkg.sv ***
package ual_pkg;

  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned REF_HZ = 6_000_000;
  localparam int unsigned CORE_HZ = 48_000_000;
  localparam int unsigned PLL_MULT = CORE_HZ / REF_HZ;

  // indicator timing, in milliseconds as specified
  localparam int unsigned LED_OFF_MS = 100;
  localparam int unsigned BLINK_ON_MS = 20;
  localparam int unsigned BLINK_PERIOD_MS = 250;

  localparam int unsigned LED_OFF_CYC = (SYS_CLK_HZ / 1000) * LED_OFF_MS;
  localparam int unsigned BLINK_ON_CYC = (SYS_CLK_HZ / 1000) * BLINK_ON_MS;
  localparam int unsigned BLINK_PERIOD_CYC = (SYS_CLK_HZ / 1000) * BLINK_PERIOD_MS;
  localparam int unsigned TMR_W = 23;

  // bit recovery: four samples per bit, data taken at the centre sample
  localparam int unsigned OVERSAMPLE = 4;
  localparam int unsigned PHASE_W = 2;
  localparam logic [1:0] SAMPLE_PHASE = 2'h2;

  // reference clock presence monitor
  localparam int unsigned REF_WIN_CYC = 256;
  localparam int unsigned REF_WIN_W = 8;
  localparam int unsigned REF_EDGES_EXP = (REF_WIN_CYC * (REF_HZ / 1000)) / (SYS_CLK_HZ / 1000);
  localparam logic [7:0] REF_EDGES_MIN = 8'((REF_EDGES_EXP + 1) / 2);

  // synchronised pin bundle positions
  localparam int unsigned PIN_W = 4;
  localparam int unsigned PIN_VBUS = 0;
  localparam int unsigned PIN_DP = 1;
  localparam int unsigned PIN_DM = 2;
  localparam int unsigned PIN_REF = 3;
  localparam logic [3:0] PIN_RST = 4'h2;

  typedef enum logic {
    UAL_DETACHED,
    UAL_ATTACHED
  } ual_attach_e;

  typedef enum logic [1:0] {
    UAL_LED_DARK,
    UAL_LED_BLINK,
    UAL_LED_ON,
    UAL_LED_ACKOFF
  } ual_led_e;

endpackage
